// file: verilog/fae_map.vh
// Constants for the automatic correction unit: layout, reset values and register offsets.
`ifndef FAE_MAP_VH
`define FAE_MAP_VH
`define FAE_UNIT_BITS       128
`define FAE_CHECK_BITS      8
`define FAE_CHECK_ERASED    8'hFF
`define FAE_FLAG_ENABLED    1'b1
`define FAE_FLAG_DISABLED   1'b0
`define FAE_OFF_IRQ_STATUS  8'h00
`define FAE_OFF_IRQ_MASK    8'h04
`define FAE_OFF_UNIT_STATUS 8'h08
`define FAE_OFF_CORR_COUNT  8'h0C
`define FAE_ST_DISABLED     0
`define FAE_ST_CHECK_ERR    1
`define FAE_ST_DATA_ERR     2
`define FAE_ST_UNCORR       3
`define FAE_EV_CORRECTED    0
`define FAE_EV_UNCORR       1
`define FAE_EV_DISABLED     2
`define FAE_EV_OTP_REFUSED  3
`define FAE_EVENTS          4
`define FAE_RESP_OKAY       2'h0
`define FAE_RESP_SLVERR     2'h2
`endif

// file: verilog/fae_ecc_calc.v
// Check value generator and single-bit locator for one 16-byte correction unit.
`timescale 1ns/10ps
`include "fae_map.vh"
module fae_ecc_calc (
	input  wire [127:0] dataIn,
	input  wire [7:0]   syndrome,
	output reg  [7:0]   checkOut,
	output reg  [127:0] flipMask
);
	// ************************************************************
	// Hamming positions skip powers of two; zeros are summed so an erased unit reads back as erased check bits.
	// ************************************************************
	integer   i;
	reg [8:0] pos;
	reg [7:0] acc;
	always @* begin
		pos      = 9'h003;
		acc      = 8'h00;
		flipMask = 128'h0;
		for (i = 0; i < `FAE_UNIT_BITS; i = i + 1) begin
			if ((pos & (pos - 9'h001)) == 9'h000) begin
				pos = pos + 9'h001;
			end
			if (!dataIn[i]) begin
				acc = acc ^ pos[7:0];
			end
			flipMask[i] = (syndrome == pos[7:0]);
			pos = pos + 9'h001;
		end
		checkOut = acc ^ `FAE_CHECK_ERASED;
	end
endmodule

// file: verilog/fae_auto_ecc.v
// Automatic correction unit logic with its register slave on AXI4-Lite.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "fae_map.vh"
module fae_auto_ecc (
	input  wire         sys_clk,
	input  wire         sys_rst,
	input  wire [7:0]   s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	output reg  [1:0]   s_axi_bresp,
	output reg          s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [7:0]   s_axi_araddr,
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	output reg  [31:0]  s_axi_rdata,
	output reg  [1:0]   s_axi_rresp,
	output reg          s_axi_rvalid,
	input  wire         s_axi_rready,
	output wire         irq,
	input  wire         pgmValid,
	input  wire [127:0] pgmData,
	input  wire [127:0] pgmOldData,
	input  wire [7:0]   pgmOldCheck,
	input  wire         pgmOldFlag,
	output reg          pgmDone,
	output reg  [7:0]   pgmCheck,
	output reg          pgmFlag,
	input  wire         ersValid,
	input  wire         ersOtp,
	output reg          ersGo,
	output reg          ersRefused,
	input  wire         rdValid,
	input  wire         rdStatusCmd,
	input  wire         rdRegSpace,
	input  wire [127:0] rdData,
	input  wire [7:0]   rdCheck,
	input  wire         rdFlag,
	output reg          rdDone,
	output reg  [127:0] rdOut,
	output reg  [7:0]   rdStatus
);
	// ************************************************************
	// Check value generation for programs and syndrome decode for reads.
	// ************************************************************
	wire [7:0]   pgmCalc;
	wire [7:0]   rdCalc;
	wire [7:0]   rdSyndrome;
	wire [127:0] rdFlip;
	fae_ecc_calc uPgmCalc (
		.dataIn   (pgmData),
		.syndrome (8'h00),
		.checkOut (pgmCalc),
		.flipMask ()
	);
	fae_ecc_calc uRdCalc (
		.dataIn   (rdData),
		.syndrome (rdSyndrome),
		.checkOut (rdCalc),
		.flipMask (rdFlip)
	);
	assign rdSyndrome = rdCalc ^ rdCheck;

	// ************************************************************
	// Program path.
	// ************************************************************
	wire pgmFirst;
	wire pgmNewlyOff;
	assign pgmFirst    = (&pgmOldData) && (pgmOldCheck == `FAE_CHECK_ERASED) && (pgmOldFlag == `FAE_FLAG_ENABLED);
	assign pgmNewlyOff = pgmValid && !pgmFirst && (pgmOldFlag == `FAE_FLAG_ENABLED);
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			pgmDone  <= 1'b0;
			pgmCheck <= `FAE_CHECK_ERASED;
			pgmFlag  <= `FAE_FLAG_ENABLED;
		end else begin
			pgmDone <= pgmValid;
			if (pgmValid) begin
				if (pgmFirst) begin
					pgmCheck <= pgmCalc;
					pgmFlag  <= `FAE_FLAG_ENABLED;
				end else begin
					pgmCheck <= pgmOldCheck;
					pgmFlag  <= `FAE_FLAG_DISABLED;
				end
			end
		end
	end

	// ************************************************************
	// Erase path.
	// ************************************************************
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ersGo      <= 1'b0;
			ersRefused <= 1'b0;
		end else begin
			ersGo      <= ersValid && !ersOtp;
			ersRefused <= ersValid && ersOtp;
		end
	end

	// ************************************************************
	// Read path and unit status.
	// ************************************************************
	wire       rdEnabled;
	wire       rdCheckErr;
	wire       rdDataErr;
	wire       rdUncorr;
	wire [7:0] rdStatusD;
	assign rdEnabled  = (rdFlag == `FAE_FLAG_ENABLED) && !rdRegSpace;
	assign rdCheckErr = rdEnabled && (rdSyndrome != 8'h00) && ((rdSyndrome & (rdSyndrome - 8'h01)) == 8'h00);
	assign rdDataErr  = rdEnabled && (|rdFlip);
	assign rdUncorr   = rdEnabled && (rdSyndrome != 8'h00) && !rdCheckErr && !rdDataErr;
	assign rdStatusD  = {4'h0, rdUncorr, rdDataErr, rdCheckErr, ~rdEnabled};
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			rdDone   <= 1'b0;
			rdOut    <= 128'h0;
			rdStatus <= 8'h00;
		end else begin
			rdDone <= rdValid;
			if (rdValid) begin
				rdStatus <= rdStatusD;
				if (rdStatusCmd) begin
					rdOut <= {120'h0, rdStatusD};
				end else if (rdDataErr) begin
					rdOut <= rdData ^ rdFlip;
				end else begin
					rdOut <= rdData;
				end
			end
		end
	end

	// ************************************************************
	// Register slave.
	// ************************************************************
	reg  [`FAE_EVENTS-1:0] irqStatus_q;
	reg  [`FAE_EVENTS-1:0] irqMask_q;
	reg  [7:0]             unitStatus_q;
	reg  [31:0]            corrCount_q;
	wire [`FAE_EVENTS-1:0] events;
	wire                   wrTake;
	wire                   rdTake;
	wire                   statusReadClr;
	wire                   countWrite;
	assign events[`FAE_EV_CORRECTED]   = rdValid && (rdDataErr || rdCheckErr);
	assign events[`FAE_EV_UNCORR]      = rdValid && rdUncorr;
	assign events[`FAE_EV_DISABLED]    = pgmNewlyOff;
	assign events[`FAE_EV_OTP_REFUSED] = ersValid && ersOtp;
	assign wrTake        = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wrTake;
	assign s_axi_wready  = wrTake;
	assign rdTake        = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rdTake;
	assign statusReadClr = rdTake && (s_axi_araddr == `FAE_OFF_IRQ_STATUS);
	assign countWrite    = wrTake && (s_axi_awaddr == `FAE_OFF_CORR_COUNT);
	assign irq           = |(irqStatus_q & irqMask_q);

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			irqStatus_q  <= {`FAE_EVENTS{1'b0}};
			unitStatus_q <= 8'h00;
			corrCount_q  <= 32'h0;
		end else begin
			irqStatus_q <= (statusReadClr ? {`FAE_EVENTS{1'b0}} : irqStatus_q) | events;
			if (rdValid && !rdRegSpace) begin
				unitStatus_q <= rdStatusD;
			end
			if (countWrite) begin
				corrCount_q <= 32'h0;
			end else if (events[`FAE_EV_CORRECTED] && (corrCount_q != 32'hFFFFFFFF)) begin
				corrCount_q <= corrCount_q + 32'h1;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			irqMask_q    <= {`FAE_EVENTS{1'b0}};
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `FAE_RESP_OKAY;
		end else begin
			if (wrTake) begin
				s_axi_bvalid <= 1'b1;
				case (s_axi_awaddr)
					`FAE_OFF_IRQ_MASK: begin
						if (s_axi_wstrb[0]) begin
							irqMask_q <= s_axi_wdata[`FAE_EVENTS-1:0];
						end
						s_axi_bresp <= `FAE_RESP_OKAY;
					end
					`FAE_OFF_IRQ_STATUS, `FAE_OFF_UNIT_STATUS, `FAE_OFF_CORR_COUNT: begin
						s_axi_bresp <= `FAE_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `FAE_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `FAE_RESP_OKAY;
		end else begin
			if (rdTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `FAE_RESP_OKAY;
				case (s_axi_araddr)
					`FAE_OFF_IRQ_STATUS: begin
						s_axi_rdata <= {{(32-`FAE_EVENTS){1'b0}}, irqStatus_q};
					end
					`FAE_OFF_IRQ_MASK: begin
						s_axi_rdata <= {{(32-`FAE_EVENTS){1'b0}}, irqMask_q};
					end
					`FAE_OFF_UNIT_STATUS: begin
						s_axi_rdata <= {24'h0, unitStatus_q};
					end
					`FAE_OFF_CORR_COUNT: begin
						s_axi_rdata <= corrCount_q;
					end
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `FAE_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: verif/fae_auto_ecc_props.sv
// Assertions on the correction unit ports.
`timescale 1ns/10ps
module fae_auto_ecc_props (
	input logic sys_clk,
	input logic sys_rst,
	input logic pgmValid,
	input logic pgmOldFlag,
	input logic pgmDone,
	input logic pgmFlag,
	input logic ersValid,
	input logic ersOtp,
	input logic ersGo,
	input logic ersRefused,
	input logic rdValid,
	input logic rdDone,
	input logic s_axi_rvalid,
	input logic s_axi_rready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	pgm_answer_a: assert property (pgmValid |=> pgmDone) else $error("no program answer");
	pgm_disable_a: assert property (pgmValid && !pgmOldFlag |=> !pgmFlag) else $error("flag set");
	erase_go_a: assert property (ersValid && !ersOtp |=> ersGo && !ersRefused) else $error("no erase");
	otp_refuse_a: assert property (ersValid && ersOtp |=> ersRefused && !ersGo) else $error("otp erased");
	read_answer_a: assert property (rdValid |=> rdDone) else $error("no read answer");
	read_quiet_a: assert property (!rdValid |=> !rdDone) else $error("stray read answer");
	erase_quiet_a: assert property (!ersValid |=> !(ersGo || ersRefused)) else $error("stray erase");
	resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
	cover property (ersValid && ersOtp);
	cover property (pgmValid && !pgmOldFlag);
	cover property (rdDone);
endmodule

// file: verif/fae_array_model.sv
// Model of one unit held in the flash array.
`timescale 1ns/10ps
module fae_array_model (
	input  logic         sys_clk,
	input  logic         pgmValid,
	input  logic [127:0] pgmData,
	input  logic         pgmDone,
	input  logic [7:0]   pgmCheck,
	input  logic         pgmFlag,
	input  logic         ersGo,
	output logic [127:0] memData = '1,
	output logic [7:0]   memCheck = 8'hFF,
	output logic         memFlag = 1'b1
);
	always @(posedge sys_clk) begin
		if (pgmValid)
			memData <= pgmData;
		if (pgmDone) begin
			memCheck <= pgmCheck;
			memFlag <= pgmFlag;
		end
		if (ersGo) begin
			memData <= '1;
			memCheck <= 8'hFF;
			memFlag <= 1'b1;
		end
	end
endmodule

// file: verif/fae_auto_ecc_tb_top.sv
// Self-checking bench for the correction unit.
`timescale 1ns/10ps
module fae_auto_ecc_tb_top;
	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, b;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic [127:0] pgmData, rdOut, memData, flipD, d, d2;
	logic [7:0]   pgmCheck, rdStatus, memCheck, flipC;
	logic         pgmValid, pgmDone, pgmFlag, ersValid, ersOtp, ersGo, ersRefused, memFlag;
	logic         rdValid, rdStatusCmd, rdRegSpace, rdDone;
	logic [31:0]  seed = 32'h65AF;
	int           fail_count = 0;
	int           tests_run = 0;
	fae_auto_ecc u_fae_auto_ecc (.*, .s_axi_wstrb(4'hF), .pgmOldData(memData), .pgmOldCheck(memCheck),
		.pgmOldFlag(memFlag), .rdData(memData ^ flipD), .rdCheck(memCheck ^ flipC), .rdFlag(memFlag));
	fae_array_model u_fae_array_model (.*);
	always #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [7:0] calc(input logic [127:0] v);
		int p = 3;
		logic [7:0] c = 8'hFF;
		for (int i = 0; i < 128; i++) begin
			if (!v[i])
				c = c ^ p[7:0];
			p = p + 1;
			if ((p & (p - 1)) == 0)
				p = p + 1;
		end
		return c;
	endfunction
	task automatic wrap_up;
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string n, input logic [136:0] e, input logic [136:0] g);
		tests_run++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
		int n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= dt;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!(w ? s_axi_awready : s_axi_arready) && n < 50);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_arvalid <= 1'b0;
		while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			wrap_up();
		end
		check("axi", {er, dt & {32{!w}}}, {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata & {32{!w}}});
	endtask
	task automatic prog(input logic [127:0] v, input logic [7:0] ec, input logic ef);
		@(posedge sys_clk);
		pgmData <= v;
		pgmValid <= 1'b1;
		@(posedge sys_clk);
		pgmValid <= 1'b0;
		#1;
		check("program", {ec, ef, 1'b1}, {pgmCheck, pgmFlag, pgmDone});
	endtask
	task automatic rd(input logic [127:0] fd, input logic [7:0] fc, input logic sc, rs,
		input logic [127:0] eo, input logic [7:0] es);
		@(posedge sys_clk);
		flipD <= fd;
		flipC <= fc;
		rdStatusCmd <= sc;
		rdRegSpace <= rs;
		rdValid <= 1'b1;
		@(posedge sys_clk);
		rdValid <= 1'b0;
		#1;
		check("read", {eo, es, 1'b1}, {rdOut, rdStatus, rdDone});
	endtask
	task automatic ers(input logic otp);
		@(posedge sys_clk);
		ersOtp <= otp;
		ersValid <= 1'b1;
		@(posedge sys_clk);
		ersValid <= 1'b0;
		#1;
		check("erase", {otp, !otp}, {ersRefused, ersGo});
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pgmValid, ersValid, ersOtp,
			rdValid, rdStatusCmd, rdRegSpace, s_axi_awaddr, s_axi_araddr, s_axi_wdata, pgmData, flipD, flipC} = '0;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		ax(0, 8'h04, 0, 2'h0);
		ax(1, 8'h04, 32'hF, 2'h0);
		ax(0, 8'h04, 32'hF, 2'h0);
		ax(1, 8'h10, 32'h0, 2'h2);
		ax(0, 8'h10, 0, 2'h2);
		$display("register test done");
		d = {rnd(), rnd(), rnd(), rnd()};
		prog(d, calc(d), 1);
		rd(0, 0, 0, 0, d, 0);
		for (int k = 0; k < 4; k++) begin
			b = rnd();
			rd(128'h1 << b[6:0], 0, 0, 0, d, 8'h04);
		end
		check("irq", 1, irq);
		ax(0, 8'h00, 32'h1, 2'h0);
		ax(0, 8'h0C, 32'h4, 2'h0);
		ax(1, 8'h0C, 32'h0, 2'h0);
		ax(0, 8'h0C, 32'h0, 2'h0);
		check("irq", 0, irq);
		rd(0, 8'h01, 0, 0, d, 8'h02);
		rd({1'b1, 126'h0, 1'b1}, 0, 0, 0, d ^ {1'b1, 126'h0, 1'b1}, 8'h08);
		ax(0, 8'h08, 32'h8, 2'h0);
		rd(1, 0, 1, 0, {120'h0, 8'h04}, 8'h04);
		rd(1, 0, 0, 1, d ^ 1, 8'h01);
		d2 = d & {4{rnd()}};
		prog(d2, calc(d), 0);
		rd(1, 0, 0, 0, d2 ^ 1, 8'h01);
		prog(d2, calc(d), 0);
		$display("correction test done");
		ers(0);
		rd(1, 0, 0, 0, '1, 8'h04);
		prog(d, calc(d), 1);
		ers(1);
		rd(0, 0, 0, 0, d, 0);
		ax(0, 8'h00, 32'hF, 2'h0);
		$display("erase test done");
		wrap_up();
	end
endmodule
bind fae_auto_ecc fae_auto_ecc_props u_fae_auto_ecc_props (.*);
